// [alert_link_pkg.sv]
// constants and types shared by the two-wire target and its alert logic
// assumes a 7-bit target address and byte-wide transfers
package alert_link_pkg;

  localparam int ADDR_W = 7;
  localparam int BYTE_W = 8;
  localparam int CNT_W = 4;
  localparam logic [ADDR_W-1:0] ADDR_BASE = 7'h0c;
  localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
  localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;
  localparam logic [CNT_W-1:0] BIT_LAST = 4'h7;
  localparam logic [CNT_W-1:0] BITS_PER_BYTE = 4'h8;
  localparam int RD_ALERT_BIT = 0;
  localparam int LINK_SYNC_W = 6;

  typedef enum logic [6:0] {
    S_IDLE     = 7'h01,
    S_ADDR     = 7'h02,
    S_ADDR_ACK = 7'h04,
    S_WR_DATA  = 7'h08,
    S_WR_ACK   = 7'h10,
    S_RD_DATA  = 7'h20,
    S_RD_ACK   = 7'h40
  } link_state_t;

endpackage

// [bus_host_model.sv]
// behavioural two-wire bus controller driving the target's pins
// assumes the bench resolves both lines with a pull-up and feeds them back
`timescale 1ns/10ps
module bus_host_model (
  input wire logic clk,
  input wire logic scl_line,
  input wire logic sda_line,
  output logic scl_oe_n,
  output logic sda_oe_n
);
  logic [7:0] res_v;
  event done;

  initial
  begin
    scl_oe_n = 1'b1;
    sda_oe_n = 1'b1;
    res_v = 8'h00;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // release clock, then wait out a stretch by the target of up to 4000 clocks
  task automatic rel_scl();
    int w;
    w = 0;
    scl_oe_n = 1'b1;
    tick(1);
    while (scl_line !== 1'b1 && w < 4000)
    begin
      tick(1);
      w++;
    end
    tick(250);
  endtask

  task automatic bit_x(input logic b, output logic r);
    tick(125);
    sda_oe_n = b;
    tick(125);
    rel_scl();
    r = sda_line;
    scl_oe_n = 1'b0;
  endtask

  task automatic start();
    sda_oe_n = 1'b0;
    tick(250);
    scl_oe_n = 1'b0;
  endtask

  task automatic stop();
    tick(125);
    sda_oe_n = 1'b0;
    tick(125);
    rel_scl();
    sda_oe_n = 1'b1;
    tick(250);
  endtask

  // one byte out, ninth bit given; reports ack or the byte read
  task automatic xfer(input logic [7:0] d, input logic ackb, input logic rd);
    logic [7:0] r;
    logic a;
    for (int i = 7; i >= 0; i--)
      bit_x(d[i], r[i]);
    bit_x(ackb, a);
    res_v = rd ? r : {7'h00, a};
    -> done;
  endtask
endmodule // bus_host_model

// [sensor_i2c_pin_interface.sv]
// two-wire target pins with strap address, clock stretching and alert line
// assumes link_clk oversamples scl well above the bus rate; pins are open drain
//
// Notes on behaviour
// - the two low address bits come from the straps, ground being 0 and supply 1.
// - with both straps low the device answers at address 0xc.
// - the data line is only ever pulled low or released, never driven high.
// - a detected event pulls the open-drain active-low alert line low.
// - a read of the device register over the bus releases the alert line.
`timescale 1ns/10ps
module sensor_i2c_pin_interface
  import alert_link_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic link_clk,
  input wire logic event_i,
  input wire logic addr_strap_bit0,
  input wire logic addr_strap_bit1,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe_n,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n,
  output logic alert_o,
  output logic alert_oe_n,
  output logic alert_active
);

  typedef struct packed {
    link_state_t state;
    logic [CNT_W-1:0] cnt;
    logic [BYTE_W-1:0] shift;
    logic rw;
    logic mack;
    logic stretch;
    logic req_tog;
    logic sda_drv_n;
    logic scl_drv_n;
    logic scl_prev;
    logic sda_prev;
  } link_reg_t;

  typedef struct packed {
    logic alert;
    logic ack_tog;
  } core_reg_t;

  link_reg_t lk_r;
  link_reg_t lk_nxt;
  core_reg_t cr_r;
  core_reg_t cr_nxt;

  logic [LINK_SYNC_W-1:0] lsync_d;
  logic [LINK_SYNC_W-1:0] lsync_q;
  logic scl_s;
  logic sda_s;
  logic strap0_s;
  logic strap1_s;
  logic alert_s;
  logic ack_s;
  logic req_s;
  logic clr_now;
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;
  logic [ADDR_W-1:0] own_addr;
  logic [BYTE_W-1:0] rd_byte;

  // link-side synchronisers for pins and core levels
  assign lsync_d = {cr_r.ack_tog, cr_r.alert, addr_strap_bit1, addr_strap_bit0, sda_i, scl_i};

  sync2 #(
    .WIDTH(LINK_SYNC_W)
  ) u_link_sync (
    .clk(link_clk),
    .arst_n(arst_n),
    .d(lsync_d),
    .q(lsync_q)
  );

  assign scl_s = lsync_q[0];
  assign sda_s = lsync_q[1];
  assign strap0_s = lsync_q[2];
  assign strap1_s = lsync_q[3];
  assign alert_s = lsync_q[4];
  assign ack_s = lsync_q[5];

  // core-side synchroniser for the read-clear toggle
  sync2 #(
    .WIDTH(1)
  ) u_core_sync (
    .clk(clk),
    .arst_n(arst_n),
    .d(lk_r.req_tog),
    .q(req_s)
  );

  // strap bits fill the low address bits
  assign own_addr = ADDR_BASE | {{(ADDR_W-2){1'b0}}, strap1_s, strap0_s};

  assign scl_rise = scl_s & ~lk_r.scl_prev;
  assign scl_fall = ~scl_s & lk_r.scl_prev;
  assign start_seen = lk_r.scl_prev & scl_s & lk_r.sda_prev & ~sda_s;
  assign stop_seen = lk_r.scl_prev & scl_s & ~lk_r.sda_prev & sda_s;

  // link-side target state machine
  always_comb
  begin
    rd_byte = '0;
    rd_byte[RD_ALERT_BIT] = alert_s;
    lk_nxt = lk_r;
    lk_nxt.scl_prev = scl_s;
    lk_nxt.sda_prev = sda_s;
    case (lk_r.state)
      S_IDLE:
      begin
        lk_nxt.sda_drv_n = 1'b1;
      end
      S_ADDR:
      begin
        if (scl_rise)
        begin
          lk_nxt.shift = {lk_r.shift[BYTE_W-2:0], sda_s};
          lk_nxt.cnt = lk_r.cnt + CNT_ONE;
        end
        else if (scl_fall && lk_r.cnt == BITS_PER_BYTE)
        begin
          if (lk_r.shift[BYTE_W-1:1] == own_addr)
          begin
            lk_nxt.state = S_ADDR_ACK;
            lk_nxt.rw = lk_r.shift[0];
            lk_nxt.sda_drv_n = 1'b0;
          end
          else
            lk_nxt.state = S_IDLE;
        end
      end
      S_ADDR_ACK:
      begin
        if (scl_fall)
        begin
          lk_nxt.cnt = CNT_ZERO;
          if (lk_r.rw)
          begin
            lk_nxt.state = S_RD_DATA;
            lk_nxt.shift = rd_byte;
            lk_nxt.sda_drv_n = rd_byte[BYTE_W-1];
          end
          else
          begin
            lk_nxt.state = S_WR_DATA;
            lk_nxt.sda_drv_n = 1'b1;
          end
        end
      end
      S_WR_DATA:
      begin
        if (scl_rise)
        begin
          lk_nxt.shift = {lk_r.shift[BYTE_W-2:0], sda_s};
          lk_nxt.cnt = lk_r.cnt + CNT_ONE;
        end
        else if (scl_fall && lk_r.cnt == BITS_PER_BYTE)
        begin
          lk_nxt.state = S_WR_ACK;
          lk_nxt.sda_drv_n = 1'b0;
        end
      end
      S_WR_ACK:
      begin
        if (scl_fall)
        begin
          lk_nxt.state = S_WR_DATA;
          lk_nxt.cnt = CNT_ZERO;
          lk_nxt.sda_drv_n = 1'b1;
        end
      end
      S_RD_DATA:
      begin
        if (scl_fall)
        begin
          if (lk_r.cnt == BIT_LAST)
          begin
            lk_nxt.state = S_RD_ACK;
            lk_nxt.sda_drv_n = 1'b1;
          end
          else
          begin
            lk_nxt.shift = {lk_r.shift[BYTE_W-2:0], 1'b0};
            lk_nxt.cnt = lk_r.cnt + CNT_ONE;
            lk_nxt.sda_drv_n = lk_r.shift[BYTE_W-2];
          end
        end
      end
      S_RD_ACK:
      begin
        if (lk_r.stretch)
        begin
          // hold scl low until the core has cleared the alert
          if (ack_s == lk_r.req_tog)
          begin
            lk_nxt.stretch = 1'b0;
            lk_nxt.scl_drv_n = 1'b1;
            lk_nxt.cnt = CNT_ZERO;
            if (lk_r.mack)
            begin
              lk_nxt.state = S_RD_DATA;
              lk_nxt.shift = rd_byte;
              lk_nxt.sda_drv_n = rd_byte[BYTE_W-1];
            end
            else
              lk_nxt.state = S_IDLE;
          end
        end
        else if (scl_rise)
          lk_nxt.mack = ~sda_s;
        else if (scl_fall)
        begin
          lk_nxt.stretch = 1'b1;
          lk_nxt.scl_drv_n = 1'b0;
          lk_nxt.req_tog = ~lk_r.req_tog;
        end
      end
      default:
      begin
        lk_nxt.state = S_IDLE;
        lk_nxt.sda_drv_n = 1'b1;
        lk_nxt.scl_drv_n = 1'b1;
      end
    endcase
    if (!lk_r.stretch)
    begin
      if (start_seen)
      begin
        lk_nxt.state = S_ADDR;
        lk_nxt.cnt = CNT_ZERO;
        lk_nxt.shift = '0;
        lk_nxt.sda_drv_n = 1'b1;
      end
      else if (stop_seen)
      begin
        lk_nxt.state = S_IDLE;
        lk_nxt.sda_drv_n = 1'b1;
      end
    end
  end

  always_ff @(posedge link_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      lk_r <= '0;
      lk_r.state <= S_IDLE;
      lk_r.sda_drv_n <= 1'b1;
      lk_r.scl_drv_n <= 1'b1;
      lk_r.scl_prev <= 1'b1;
      lk_r.sda_prev <= 1'b1;
    end
    else
      lk_r <= lk_nxt;
  end

  // core-side alert latch, set wins over clear
  assign clr_now = req_s != cr_r.ack_tog;

  always_comb
  begin
    cr_nxt = cr_r;
    if (clr_now)
    begin
      cr_nxt.ack_tog = req_s;
      cr_nxt.alert = 1'b0;
    end
    if (event_i)
      cr_nxt.alert = 1'b1;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      cr_r <= '0;
    else
      cr_r <= cr_nxt;
  end

  // open-drain pins only ever pull low
  assign sda_o = 1'b0;
  assign sda_oe_n = lk_r.sda_drv_n;
  assign scl_o = 1'b0;
  assign scl_oe_n = lk_r.scl_drv_n;
  assign alert_o = 1'b0;
  assign alert_oe_n = ~cr_r.alert;
  assign alert_active = cr_r.alert;

  // checks on the core domain
  alert_set_a: assert property (@(posedge clk) disable iff (!arst_n)
    event_i |=> !alert_oe_n)
    else $error("alert not pulled low after event");

  alert_hold_a: assert property (@(posedge clk) disable iff (!arst_n)
    (!alert_oe_n && !clr_now) |=> !alert_oe_n)
    else $error("alert released without a read");

  alert_release_a: assert property (@(posedge clk) disable iff (!arst_n)
    (clr_now && !event_i) |=> (alert_oe_n && cr_r.ack_tog == $past(req_s)))
    else $error("alert not released after read");

  // checks on the link domain
  sda_drive_a: assert property (@(posedge link_clk) disable iff (!arst_n)
    !sda_oe_n |-> (lk_r.state inside {S_ADDR_ACK, S_WR_ACK, S_RD_DATA}))
    else $error("data line pulled low outside a drive phase");

  addr_strap_a: assert property (@(posedge link_clk) disable iff (!arst_n)
    (lk_r.state == S_ADDR_ACK && $past(lk_r.state) == S_ADDR)
      |-> ($past(lk_r.shift[2:1]) == $past({strap1_s, strap0_s})))
    else $error("acked address with wrong strap bits");

  addr_base_a: assert property (@(posedge link_clk) disable iff (!arst_n)
    (lk_r.state == S_ADDR_ACK && $past(lk_r.state) == S_ADDR
      && $past({strap1_s, strap0_s}) == 2'h0)
      |-> ($past(lk_r.shift[BYTE_W-1:1]) == ADDR_BASE))
    else $error("acked address differs from base");

  read_clear_a: assert property (@(posedge link_clk) disable iff (!arst_n)
    ($rose(lk_r.stretch)) |-> (lk_r.req_tog != $past(lk_r.req_tog) && !scl_oe_n))
    else $error("read end did not request clear and stretch");

  stretch_hold_a: assert property (@(posedge link_clk) disable iff (!arst_n)
    (lk_r.stretch && ack_s != lk_r.req_tog) |=> !scl_oe_n)
    else $error("clock released before clear handshake");

endmodule // sensor_i2c_pin_interface

// [sensor_i2c_pin_interface_bench.sv]
// self-checking bench: strap addresses, alert set and clear over a bus read
// assumes the host model and the design files are compiled first
`timescale 1ns/10ps
module sensor_i2c_pin_interface_bench import alert_link_pkg::*;;
  logic clk, link_clk, arst_n, event_i, strap0, strap1;
  logic scl_o, scl_oe_n, sda_o, sda_oe_n, alert_o, alert_oe_n, alert_active;
  logic h_scl_oe_n, h_sda_oe_n, scl_line, sda_line;
  logic [6:0] bad;
  logic [9:0] q[$];
  int error_cnt, total_checks, seed;
  event probe;

  assign scl_line = scl_oe_n & h_scl_oe_n;
  assign sda_line = sda_oe_n & h_sda_oe_n;

  sensor_i2c_pin_interface sensor_i2c_pin_interface_i (.clk(clk), .arst_n(arst_n),
    .link_clk(link_clk), .event_i(event_i), .addr_strap_bit0(strap0),
    .addr_strap_bit1(strap1), .scl_i(scl_line), .scl_o(scl_o), .scl_oe_n(scl_oe_n),
    .sda_i(sda_line), .sda_o(sda_o), .sda_oe_n(sda_oe_n), .alert_o(alert_o),
    .alert_oe_n(alert_oe_n), .alert_active(alert_active));

  bus_host_model bus_host_model_i (.clk(clk), .scl_line(scl_line), .sda_line(sda_line),
    .scl_oe_n(h_scl_oe_n), .sda_oe_n(h_sda_oe_n));

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  initial
  begin
    link_clk = 1'b0;
    #7.3;
    forever #24 link_clk = ~link_clk;
  end

  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    total_checks++;
    if (s !== e)
    begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic cmp_ack(input logic [7:0] e, input logic [7:0] s);
    chk("ack", e, s);
  endtask

  task automatic cmp_byte(input logic [7:0] e, input logic [7:0] s);
    chk("byte", e, s);
  endtask

  task automatic cmp_pins(input logic [7:0] e);
    chk("pins", e, {3'h0, alert_oe_n, alert_active, alert_o, sda_o, scl_o});
  endtask

  task automatic pins(input logic oe_n, input logic act);
    q.push_back({2'h2, 3'h0, oe_n, act, 3'h0});
    -> probe;
  endtask

  task automatic rd(input logic [6:0] a, input logic hit, input logic [7:0] b,
    input logic more);
    logic [7:0] e;
    e = b;
    q.push_back({2'h0, 7'h00, !hit});
    bus_host_model_i.start();
    bus_host_model_i.xfer({a, 1'b1}, 1'b1, 1'b0);
    if (hit && more)
    begin
      q.push_back({2'h1, e});
      bus_host_model_i.xfer(8'hff, 1'b0, 1'b1);
      e = 8'h00;
    end
    if (hit)
    begin
      q.push_back({2'h1, e});
      bus_host_model_i.xfer(8'hff, 1'b1, 1'b1);
    end
    bus_host_model_i.stop();
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    q.push_back({2'h0, 8'h00});
    bus_host_model_i.start();
    bus_host_model_i.xfer({a, 1'b0}, 1'b1, 1'b0);
    q.push_back({2'h0, 8'h00});
    bus_host_model_i.xfer(d, 1'b1, 1'b0);
    bus_host_model_i.stop();
  endtask

  task automatic conclude();
    if (error_cnt == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // takes the oldest note whenever a result or a pin probe appears
  initial
  begin
    logic [9:0] n;
    forever
    begin
      @(bus_host_model_i.done or probe);
      n = q.pop_front();
      if (n[9:8] == 2'h0)
        cmp_ack(n[7:0], bus_host_model_i.res_v);
      else if (n[9:8] == 2'h1)
        cmp_byte(n[7:0], bus_host_model_i.res_v);
      else
        cmp_pins(n[7:0]);
    end
  end

  initial
  begin
    repeat (80000) @(posedge clk);
    error_cnt++;
    conclude();
  end

  initial
  begin
    error_cnt = 0;
    total_checks = 0;
    seed = 32'hff9417bb;
    arst_n = 1'b0;
    event_i = 1'b0;
    strap0 = 1'b0;
    strap1 = 1'b0;
    repeat (10) @(posedge clk);
    #1;
    arst_n = 1'b1;
    bus_host_model_i.tick(60);
    pins(1'b1, 1'b0);
    for (int s = 0; s < 4; s++)
    begin
      {strap1, strap0} = s[1:0];
      bus_host_model_i.tick(60);
      if (s[0])
      begin
        event_i = 1'b1;
        bus_host_model_i.tick(1 + ($random(seed) & 7));
        event_i = 1'b0;
        bus_host_model_i.tick(2);
        pins(1'b0, 1'b1);
        bus_host_model_i.tick(300 + ($random(seed) & 255));
        pins(1'b0, 1'b1);
        if (s[1])
        begin
          wr(ADDR_BASE | 7'(s), 8'($random(seed)));
          pins(1'b0, 1'b1);
        end
      end
      rd(ADDR_BASE | 7'(s), 1'b1, {7'h00, s[0]}, s[1]);
      pins(1'b1, 1'b0);
    end
    bad = 7'($random(seed));
    if (bad == (ADDR_BASE | 7'h03))
      bad = bad ^ 7'h01;
    rd(bad, 1'b0, 8'h00, 1'b0);
    bus_host_model_i.tick(10);
    conclude();
  end
endmodule // sensor_i2c_pin_interface_bench

// [sync2.sv]
// two flip-flop synchroniser for a vector of independent levels
// assumes each bit is a level or toggle that changes slowly vs the clock
`timescale 1ns/10ps
module sync2 #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } sync_reg_t;

  sync_reg_t st_r;
  sync_reg_t st_nxt;

  always_comb
  begin
    st_nxt = st_r;
    st_nxt.meta = d;
    st_nxt.stable = st_r.meta;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign q = st_r.stable;

endmodule // sync2
